//--- core/adcs_clkdiv.sv
`timescale 1ns/1ps
module adcs_clkdiv (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [2:0] conversion_clock_divider_select,
	output logic tick
);
	logic [6:0] cnt_q;
	logic [6:0] limit;

	// limit = 2^sel - 1, one tick per converter clock
	assign limit = 7'((8'h01 << conversion_clock_divider_select) - 8'h01);
	assign tick = (cnt_q >= limit);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= adcs_pkg::div_reset;
		end else if (tick) begin
			cnt_q <= adcs_pkg::div_reset;
		end else begin
			cnt_q <= cnt_q + 7'h01;
		end
	end
endmodule

//--- core/adcs_pkg.sv
package adcs_pkg;
	localparam int unsigned sys_clk_mhz = 100;
	localparam logic [2:0] src_internal = 3'h1;
	localparam logic [2:0] src_gnd_lo = 3'h2;
	localparam logic [2:0] src_gnd_hi = 3'h4;
	localparam logic [3:0] chan_last_ext = 4'h5;
	localparam int unsigned num_ext = 6;
	localparam logic [4:0] sample_cycles = 5'h04;
	localparam logic [4:0] convert_cycles = 5'h0c;
	localparam logic [4:0] total_cycles = 5'h10;
	localparam int unsigned result_bits = 12;
	localparam logic [11:0] full_scale = 12'hfff;
	localparam logic [11:0] result_reset = 12'h000;
	localparam logic [6:0] div_reset = 7'h00;

	typedef enum logic [1:0] {
		adcs_mux_none,
		adcs_mux_ext,
		adcs_mux_internal,
		adcs_mux_ground
	} adcs_mux_kind_t;

	typedef struct packed {
		adcs_mux_kind_t kind;
		logic [num_ext-1:0] ext_onehot;
	} adcs_mux_t;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} adcs_result_t;
endpackage

//--- core/adcs_top.sv
`timescale 1ns/1ps
// Contract
// - pin-function select chooses analog input or other function; analog disables others
// - pull-up on a pin is disconnected while it is analog input
// - analog selection overrides port direction control
// - external source settings with codes 0..5 route external inputs 0..5
// - external source settings with codes 6..15 connect nothing, input floats
// - source 001 routes internal amplified signal; 010..100 connect ground
// - conversion: 4 converter clocks sampling then 12 converting, 16 total
// - conversion runs autonomously without stalling the processor
// - start bit low, high, low starts a conversion
// - busy flag high during conversion, low at end with valid result
// - power enable low switches converter circuitry off
// - result is 12-bit code, full scale fff, step reference over 4096
// - format select arranges 12-bit result across high and low bytes
// - divider select divides system clock by 1 up to 128
// - busy flag set by hardware as soon as conversion starts
// - at completion set interrupt flag and raise interrupt if enabled
module adcs_top (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [5:0] pin_function_select,
	input wire logic [5:0] port_dir_input,
	input wire logic [5:0] port_pullup_enable,
	input wire logic [5:0] port_out_value,
	input wire logic [2:0] input_source_select,
	input wire logic [3:0] channel_select,
	input wire logic converter_power_enable,
	input wire logic [2:0] conversion_clock_divider_select,
	input wire logic [1:0] reference_source_select,
	input wire logic result_format_select,
	input wire logic start,
	input wire logic global_interrupt_enable,
	input wire logic converter_interrupt_enable,
	input wire logic converter_interrupt_flag_clear,
	input wire logic [11:0] sar_code,
	output logic [5:0] pin_digital_enable,
	output logic [5:0] pin_output_enable,
	output logic [5:0] pin_output,
	output logic [5:0] pin_pullup_on,
	output logic [5:0] pin_analog_connect,
	output adcs_pkg::adcs_mux_t mux_sel,
	output logic [1:0] reference_select_out,
	output logic analog_power_on,
	output logic sample_hold,
	output logic conversion_in_progress_flag,
	output logic converter_interrupt_flag,
	output logic converter_interrupt,
	output adcs_pkg::adcs_result_t result
);
	typedef enum logic [1:0] {
		adcs_idle,
		adcs_sample,
		adcs_convert
	} adcs_state_t;

	adcs_state_t state_q;
	logic tick;
	logic start_q;
	logic armed_q;
	logic fire;
	logic [4:0] cyc_q;
	logic done;
	adcs_pkg::adcs_mux_t mux_d;

	function automatic adcs_pkg::adcs_mux_t decode_mux(input logic [2:0] src, input logic [3:0] ch);
		adcs_pkg::adcs_mux_t m;
		m.kind = adcs_pkg::adcs_mux_none;
		m.ext_onehot = '0;
		if (src == adcs_pkg::src_internal) begin
			m.kind = adcs_pkg::adcs_mux_internal;
		end else if (src >= adcs_pkg::src_gnd_lo && src <= adcs_pkg::src_gnd_hi) begin
			m.kind = adcs_pkg::adcs_mux_ground;
		end else if (ch <= adcs_pkg::chan_last_ext) begin
			m.kind = adcs_pkg::adcs_mux_ext;
			m.ext_onehot = 6'(7'h01 << ch);
		end
		// remaining codes leave input floating
		return m;
	endfunction

	adcs_clkdiv u_div (
		.sys_clk(sys_clk),
		.rst(rst),
		.conversion_clock_divider_select(conversion_clock_divider_select),
		.tick(tick)
	);

	// pads stay combinational so a function change acts at once
	// analog pins lose digital drive, pull-up and direction control
	assign pin_digital_enable = ~pin_function_select;
	assign pin_output_enable = port_dir_input == 6'h3f ? 6'h00 :
		~port_dir_input & ~pin_function_select;
	assign pin_output = port_out_value & ~pin_function_select;
	assign pin_pullup_on = port_pullup_enable & ~pin_function_select;

	assign mux_d = decode_mux(input_source_select, channel_select);
	// source select has priority: internal or ground leaves ext_onehot clear, so no external input joins it
	// registered so the converter input never sees a half-changed select
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mux_sel <= '0;
		end else begin
			mux_sel <= mux_d;
		end
	end

	// pin switch closes only for a pin that software made analog
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pin_analog_connect <= 6'h00;
		end else begin
			pin_analog_connect <= mux_d.ext_onehot & pin_function_select;
		end
	end

	assign reference_select_out = reference_source_select;
	assign analog_power_on = converter_power_enable;

	// start pulse: rising edge arms, falling edge fires
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			start_q <= 1'b0;
		end else begin
			start_q <= start;
		end
	end

	// arm cleared on power-off so a pulse begun while off never fires
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else if (!converter_power_enable) begin
			armed_q <= 1'b0;
		end else if (start && !start_q) begin
			armed_q <= 1'b1;
		end else if (!start && start_q) begin
			armed_q <= 1'b0;
		end
	end
	assign fire = armed_q && start_q && !start && converter_power_enable;

	assign done = (state_q == adcs_convert) && tick && (cyc_q == adcs_pkg::total_cycles - 5'h01);

	// sequencer runs on its own; processor never waits
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= adcs_idle;
			cyc_q <= 5'h00;
		end else if (!converter_power_enable) begin
			state_q <= adcs_idle;
			cyc_q <= 5'h00;
		end else if (fire) begin
			// a pulse mid-conversion restarts; the earlier result is lost
			state_q <= adcs_sample; // restart on new pulse
			cyc_q <= 5'h00;
		end else begin
			case (state_q)
				adcs_idle: begin
					cyc_q <= 5'h00;
				end
				adcs_sample: begin
					if (tick) begin
						cyc_q <= cyc_q + 5'h01;
						if (cyc_q == adcs_pkg::sample_cycles - 5'h01) begin
							state_q <= adcs_convert;
						end
					end
				end
				adcs_convert: begin
					if (done) begin
						state_q <= adcs_idle;
						cyc_q <= 5'h00;
					end else if (tick) begin
						cyc_q <= cyc_q + 5'h01;
					end
				end
				default: begin
					state_q <= adcs_idle;
				end
			endcase
		end
	end

	assign sample_hold = (state_q == adcs_sample);
	assign conversion_in_progress_flag = (state_q != adcs_idle);

	// completion flag: set beats clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			converter_interrupt_flag <= 1'b0;
		end else if (done) begin
			converter_interrupt_flag <= 1'b1;
		end else if (converter_interrupt_flag_clear) begin
			converter_interrupt_flag <= 1'b0;
		end
	end
	assign converter_interrupt = converter_interrupt_flag && converter_interrupt_enable
		&& global_interrupt_enable;

	// format bit read only at completion, so changing it mid-run is harmless
	// both bytes latched at once so a read mid-conversion sees the old pair
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			result <= '0;
		end else if (done) begin
			if (result_format_select) begin
				result <= {4'h0, sar_code[11:8], sar_code[7:0]};
			end else begin
				result <= {sar_code[11:4], sar_code[3:0], 4'h0};
			end
		end
	end
endmodule

//--- tb/adcs_checker.sv
`timescale 1ns/1ps
module adcs_checker (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [5:0] pin_function_select,
	input wire logic [5:0] port_pullup_enable,
	input wire logic converter_power_enable,
	input wire logic [2:0] conversion_clock_divider_select,
	input wire logic start,
	input wire logic global_interrupt_enable,
	input wire logic converter_interrupt_enable,
	input wire logic [5:0] pin_pullup_on,
	input wire logic sample_hold,
	input wire logic conversion_in_progress_flag,
	input wire logic converter_interrupt_flag,
	input wire logic converter_interrupt,
	input wire adcs_pkg::adcs_result_t result
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_pullup_off: assert property (pin_pullup_on == (port_pullup_enable & ~pin_function_select))
		else $error("pullup left on");
	a_start_busy: assert property ($rose(start) && converter_power_enable ##1 $fell(start) && converter_power_enable
		|=> conversion_in_progress_flag) else $error("busy not set");
	a_power_off: assert property (!converter_power_enable |=> !conversion_in_progress_flag)
		else $error("busy while off");
	a_sample_len: assert property ($rose(sample_hold) && conversion_clock_divider_select == 3'h0
		|-> sample_hold[*4] ##1 !sample_hold) else $error("sampling length");
	a_convert_len: assert property ($fell(sample_hold) && conversion_in_progress_flag && conversion_clock_divider_select == 3'h0
		|-> conversion_in_progress_flag[*8] ##1 conversion_in_progress_flag[*4] ##1 !conversion_in_progress_flag)
		else $error("convert length");
	a_result_hold: assert property ($changed(result) |-> $fell(conversion_in_progress_flag))
		else $error("result moved");
	a_flag_set: assert property ($rose(converter_interrupt_flag) |-> $fell(conversion_in_progress_flag))
		else $error("flag timing");
	a_irq_gate: assert property (converter_interrupt ==
		(converter_interrupt_flag & global_interrupt_enable & converter_interrupt_enable)) else $error("irq gate");
endmodule
bind adcs_top adcs_checker chk_u (.sys_clk, .rst, .pin_function_select, .port_pullup_enable, .converter_power_enable,
	.conversion_clock_divider_select, .start, .global_interrupt_enable, .converter_interrupt_enable, .pin_pullup_on,
	.sample_hold, .conversion_in_progress_flag, .converter_interrupt_flag, .converter_interrupt, .result);

//--- tb/adcs_sar_model.sv
`timescale 1ns/1ps
module adcs_sar_model (
	input wire logic sys_clk,
	input wire adcs_pkg::adcs_mux_t mux_sel,
	output logic [11:0] sar_code
);
	initial sar_code = 12'h000;
	always @(posedge sys_clk) begin
		case (mux_sel.kind)
			adcs_pkg::adcs_mux_ext: sar_code <= {6'h2a, mux_sel.ext_onehot};
			adcs_pkg::adcs_mux_internal: sar_code <= adcs_pkg::full_scale;
			adcs_pkg::adcs_mux_ground: sar_code <= 12'h000;
			// floating input, never a stable code
			default: sar_code <= ~sar_code;
		endcase
	end
endmodule

//--- tb/adcs_top_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin n_fail++; $display("Error %s exp %h got %h", n, e, a); end end
module adcs_top_bench;
	logic sys_clk = 1'b0, rst = 1'b1, start = 1'b0, converter_power_enable = 1'b0, result_format_select = 1'b1;
	logic global_interrupt_enable = 1'b0, converter_interrupt_enable = 1'b0, converter_interrupt_flag_clear = 1'b0;
	logic [5:0] pin_function_select = 6'h15, port_dir_input = 6'h00, port_pullup_enable = 6'h3f, port_out_value = 6'h3f;
	logic [5:0] pin_digital_enable, pin_output_enable, pin_output, pin_pullup_on, pin_analog_connect;
	logic [3:0] channel_select = 4'h0;
	logic [2:0] input_source_select = 3'h0, conversion_clock_divider_select = 3'h0;
	logic [1:0] reference_source_select = 2'h2, reference_select_out;
	logic [11:0] sar_code;
	logic analog_power_on, sample_hold, conversion_in_progress_flag, converter_interrupt_flag, converter_interrupt;
	adcs_pkg::adcs_mux_t mux_sel;
	adcs_pkg::adcs_result_t result;
	int n_fail = 0, n_checks = 0, n;
	always #5 sys_clk = ~sys_clk;
	adcs_top dut_u (.*);
	adcs_sar_model model_u (.sys_clk(sys_clk), .mux_sel(mux_sel), .sar_code(sar_code));
	task automatic stop_test;
		if (n_fail == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// counts busy cycles; a refused start gives up after a few cycles
	task automatic conv(input logic [2:0] d, output int cnt);
		int i;
		conversion_clock_divider_select = d;
		start = 1'b1;
		@(negedge sys_clk);
		start = 1'b0;
		cnt = 0;
		for (i = 0; i < 3000; i++) begin
			@(negedge sys_clk);
			if (conversion_in_progress_flag === 1'b1) cnt++;
			else if (cnt > 0 || i > 4) break;
		end
		if (i == 3000) begin
			n_fail++;
			stop_test();
		end
	endtask
	task automatic run(input logic [2:0] src, input logic [3:0] ch, input logic [11:0] code);
		logic [5:0] sw;
		channel_select = ch;
		input_source_select = src;
		result_format_select = ~result_format_select;
		sw = (src inside {3'h0, [3'h5:3'h7]} && ch < 4'h6) ? 6'(7'h01 << ch) & pin_function_select : 6'h00;
		conv(3'h0, n);
		`CHK("cycles", 16, n)
		`CHK("result", result_format_select ? {4'h0, code} : {code, 4'h0}, result)
		`CHK("connect", sw, pin_analog_connect)
	endtask
	initial begin
		repeat (6) @(negedge sys_clk);
		rst = 1'b0;
		`CHK("oe", 6'h2a, pin_output_enable)
		`CHK("pullup", 6'h2a, pin_pullup_on)
		`CHK("digital", 6'h2a, pin_digital_enable)
		`CHK("out", 6'h2a, pin_output)
		`CHK("ref", 2'h2, reference_select_out)
		port_dir_input = 6'h03;
		@(negedge sys_clk);
		`CHK("dir", 6'h28, pin_output_enable)
		conv(3'h0, n);
		`CHK("off", 0, n)
		converter_power_enable = 1'b1;
		for (int k = 0; k < 6; k++) run(3'h0, 4'(k), {6'h2a, 6'(1 << k)});
		for (int s = 5; s < 8; s++) run(3'(s), 4'h2, {6'h2a, 6'h04});
		channel_select = 4'h9;
		input_source_select = 3'h0;
		repeat (2) @(negedge sys_clk);
		`CHK("float", adcs_pkg::adcs_mux_none, mux_sel.kind)
		run(3'h1, 4'hf, adcs_pkg::full_scale);
		for (int s = 2; s < 5; s++) run(3'(s), 4'h0, 12'h000);
		`CHK("irq", 1'b0, converter_interrupt)
		global_interrupt_enable = 1'b1;
		converter_interrupt_enable = 1'b1;
		@(negedge sys_clk);
		`CHK("irq", 1'b1, converter_interrupt)
		for (int d = 0; d < 8; d++) begin
			conv(3'(d), n);
			`CHK("span", 1'b1, n > 15 * (2 ** d) && n <= 16 * (2 ** d))
		end
		converter_interrupt_flag_clear = 1'b1;
		conversion_clock_divider_select = 3'h2;
		start = 1'b1;
		@(negedge sys_clk);
		converter_interrupt_flag_clear = 1'b0;
		start = 1'b0;
		repeat (20) @(negedge sys_clk);
		`CHK("busy", 1'b1, conversion_in_progress_flag)
		converter_power_enable = 1'b0;
		repeat (80) @(negedge sys_clk);
		`CHK("abort", 2'b00, {conversion_in_progress_flag, converter_interrupt_flag})
		`CHK("power", 1'b0, analog_power_on)
		stop_test();
	end
endmodule
